// ===== include/pwm_gen_defs.vh
// register offsets, field positions and reset values of the pwm generator
// Contract
// - period ends when the 8-bit time base counter equals the period register.
// - next increment after match clears counter, sets output, loads buffered duty.
// - zero duty never sets the output, so it stays low all period.
// - postscaler ignored for period; it only divides match events for an update flag.
// - duty is 10 bits: low-byte register on top, control bits 5:4 below.
// - duty writes accepted anytime but applied only at the next period match.
// - in pwm mode the active duty byte is read-only to software.
// - active byte plus hidden 2-bit latch form the glitch-free working duty.
// - output cleared when active duty equals counter extended by two fine bits (phase at prescale 1, prescaler bits otherwise).
// - duty above period never reaches the clear match; output stays high.
// - prescale ratios 1, 4 and 16 chosen by the timer control prescale field.
// - resolution equals log2 of oscillator to pwm frequency ratio.
// - the time base counts only while timer control bit 2 is set.
// - clearing the whole unit control register forces the output latch low.
`ifndef PWM_GEN_DEFS_VH
`define PWM_GEN_DEFS_VH

// register addresses
`define ADDR_COUNTER        4'h0
`define ADDR_PERIOD         4'h1
`define ADDR_TB_CONTROL     4'h2
`define ADDR_DUTY_LOW       4'h3
`define ADDR_DUTY_ACTIVE    4'h4
`define ADDR_UNIT_CONTROL   4'h5
`define ADDR_IRQ_STATUS     4'h6
`define ADDR_IRQ_MASK       4'h7

// time base control fields
`define TBC_PRESCALE_LSB    0
`define TBC_RUN_BIT         2
`define TBC_POST_LSB        3
// unit control fields
`define UC_MODE_LSB         0
`define UC_DUTY_LSB_LSB     4
`define UC_PWM_MODE         4'hC
// interrupt status bits
`define IRQ_PERIOD_BIT      0
`define IRQ_POSTSCALE_BIT   1

// reset values
`define RST_BYTE            8'h00
`define RST_PERIOD          8'hFF
`define RST_IRQ             2'h0

`endif

// ===== logic/pwm_period_duty_generator.v
// pwm generator: time base, prescaler, double-buffered duty and register port
//
// Local design decisions: strobed register access and the address map.
`include "pwm_gen_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module pwm_period_duty_generator (
    // clock and reset
    input  wire        mclk,
    input  wire        reset_n,
    // register port
    input  wire [3:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [7:0]  rdata,
    // pwm pin and interrupt
    output reg         unit2_output_pin,
    output reg         irq
);

    // software registers
    reg [7:0] time_base_counter_q;
    reg [7:0] time_base_period_q;
    reg [6:0] time_base_control_q;
    reg [7:0] unit2_duty_low_byte_q;
    reg [7:0] unit2_duty_active_byte_q;
    reg [5:0] unit2_control_q;
    reg [1:0] duty_latch_q;          // hidden two low duty bits
    reg [1:0] phase_q;               // quarter-cycle phase
    reg [3:0] prescale_q;            // prescaler counter
    reg [3:0] post_cnt_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;

    wire       wr_unit    = wr_stb && (addr == `ADDR_UNIT_CONTROL);
    wire       pwm_mode   = (unit2_control_q[3:0] == `UC_PWM_MODE);
    wire       run        = time_base_control_q[`TBC_RUN_BIT];
    wire [1:0] ps_sel     = time_base_control_q[1:0];
    wire [3:0] post_sel   = time_base_control_q[6:3];

    // prescaler terminal counts 0, 3, 15 divide the quarter-cycle tick by 1, 4, 16
    reg [3:0] ps_last;
    always @* begin
        case (ps_sel)
            2'h0:    ps_last = 4'h0;
            2'h1:    ps_last = 4'h3;
            default: ps_last = 4'hF;
        endcase
    end

    // one counter increment every four oscillator phases times prescale
    wire tick_phase = run && (phase_q == 2'h3);
    wire inc        = tick_phase && (prescale_q == ps_last);
    wire match      = (time_base_counter_q == time_base_period_q);
    wire wrap       = inc && match;

    // fine bits: phase for prescale 1, prescaler bits otherwise
    wire [1:0] fine = (ps_sel == 2'h0) ? phase_q :
                      (ps_sel == 2'h1) ? prescale_q[1:0] : prescale_q[3:2];
    wire [9:0] active_duty = {unit2_duty_active_byte_q, duty_latch_q};
    wire [9:0] next_duty   = {unit2_duty_low_byte_q, unit2_control_q[5:4]};
    // fine bits advance every mclk at prescale 1, every quarter-cycle tick at prescale 4, every fourth tick at prescale 16
    wire       fine_adv    = (ps_sel == 2'h0) ? run :
                             (ps_sel == 2'h1) ? tick_phase :
                             (tick_phase && (prescale_q[1:0] == 2'h3));
    // compare against the position about to be entered so high time is duty units exactly
    wire [9:0] next_pos    = {time_base_counter_q, fine} + 10'h001;
    wire       clr_match   = fine_adv && (active_duty == next_pos);

    // postscaler divides matches only for the update flag
    wire post_evt = wrap && (post_cnt_q == post_sel);

    // phase, prescaler and time base counter
    always @(posedge mclk) begin
        if (!reset_n) begin
            phase_q             <= 2'h0;
            prescale_q          <= 4'h0;
            time_base_counter_q <= `RST_BYTE;
        end else begin
            if (run) begin
                phase_q <= phase_q + 2'h1;
            end
            if (tick_phase) begin
                prescale_q <= (prescale_q == ps_last) ? 4'h0 : prescale_q + 4'h1;
            end
            if (wr_stb && addr == `ADDR_COUNTER) begin
                time_base_counter_q <= wdata;
            end else if (wrap) begin
                time_base_counter_q <= 8'h00;
            end else if (inc) begin
                time_base_counter_q <= time_base_counter_q + 8'h01;
            end
        end
    end

    // software-written registers
    always @(posedge mclk) begin
        if (!reset_n) begin
            time_base_period_q    <= `RST_PERIOD;
            time_base_control_q   <= 7'h00;
            unit2_duty_low_byte_q <= `RST_BYTE;
            unit2_control_q       <= 6'h00;
            irq_mask_q            <= `RST_IRQ;
        end else if (wr_stb) begin
            case (addr)
                `ADDR_PERIOD:       time_base_period_q    <= wdata;
                `ADDR_TB_CONTROL:   time_base_control_q   <= wdata[6:0];
                `ADDR_DUTY_LOW:     unit2_duty_low_byte_q <= wdata;
                `ADDR_UNIT_CONTROL: unit2_control_q       <= wdata[5:0];
                `ADDR_IRQ_MASK:     irq_mask_q            <= wdata[1:0];
                default: ;
            endcase
        end
    end

    // active duty: loaded only at period wrap; plain write outside pwm mode
    always @(posedge mclk) begin
        if (!reset_n) begin
            unit2_duty_active_byte_q <= `RST_BYTE;
            duty_latch_q             <= 2'h0;
        end else if (pwm_mode && wrap) begin
            unit2_duty_active_byte_q <= next_duty[9:2];
            duty_latch_q             <= next_duty[1:0];
        end else if (!pwm_mode && wr_stb && addr == `ADDR_DUTY_ACTIVE) begin
            unit2_duty_active_byte_q <= wdata;
        end
    end

    // output latch
    always @(posedge mclk) begin
        if (!reset_n) begin
            unit2_output_pin <= 1'b0;
        end else if (wr_unit && wdata == 8'h00) begin
            unit2_output_pin <= 1'b0;
        end else if (!pwm_mode) begin
            unit2_output_pin <= 1'b0;
        end else if (wrap) begin
            unit2_output_pin <= (next_duty != 10'h000);
        end else if (clr_match) begin
            unit2_output_pin <= 1'b0;
        end
    end

    // postscale counter and sticky interrupt status, set wins over clear
    always @(posedge mclk) begin
        if (!reset_n) begin
            post_cnt_q   <= 4'h0;
            irq_status_q <= `RST_IRQ;
            irq          <= 1'b0;
        end else begin
            if (wrap) begin
                post_cnt_q <= post_evt ? 4'h0 : post_cnt_q + 4'h1;
            end
            irq_status_q <= (irq_status_q & ~((wr_stb && addr == `ADDR_IRQ_STATUS) ? wdata[1:0] : 2'h0))
                            | {post_evt, wrap};
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // read data one cycle after the strobe
    always @(posedge mclk) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            case (addr)
                `ADDR_COUNTER:      rdata <= time_base_counter_q;
                `ADDR_PERIOD:       rdata <= time_base_period_q;
                `ADDR_TB_CONTROL:   rdata <= {1'b0, time_base_control_q};
                `ADDR_DUTY_LOW:     rdata <= unit2_duty_low_byte_q;
                `ADDR_DUTY_ACTIVE:  rdata <= unit2_duty_active_byte_q;
                `ADDR_UNIT_CONTROL: rdata <= {2'h0, unit2_control_q};
                `ADDR_IRQ_STATUS:   rdata <= {6'h00, irq_status_q};
                `ADDR_IRQ_MASK:     rdata <= {6'h00, irq_mask_q};
                default:            rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // pwm_period_duty_generator
`default_nettype wire

// ===== sim/pwm_load_model.sv
// load model: measures pulse width and period seen on the pwm pin
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
    // clock and pin
    input  wire logic       mclk,
    input  wire logic       unit2_output_pin,
    // measurements: high time and period in mclk cycles, count of rising edges
    output var logic [15:0] last_high = 16'h0000,
    output var logic [15:0] last_period = 16'h0000,
    output var logic [15:0] rises = 16'h0000
);
    logic [15:0] hi = 16'h0000;
    logic [15:0] per = 16'h0000;
    logic        prev = 1'b0;
    // count high samples per pulse and samples between rising edges
    always @(posedge mclk) begin
        if (unit2_output_pin && !prev) begin
            last_period <= per;
            per <= 16'h0001;
            rises <= rises + 16'h0001;
            hi <= 16'h0001;
        end else begin
            per <= per + 16'h0001;
            if (unit2_output_pin) hi <= hi + 16'h0001;
        end
        if (!unit2_output_pin && prev) last_high <= hi;
        prev <= unit2_output_pin;
    end
endmodule // pwm_load_model
`default_nettype wire

// ===== sim/pwm_period_duty_generator_chk.sv
// assertion checker for the pwm generator port and pin
`timescale 1ns/1ns
`default_nettype none
module pwm_period_duty_generator_chk (
    // clock and register port
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    // outputs
    input wire logic [7:0] rdata,
    input wire logic       unit2_output_pin,
    input wire logic       irq
);
    logic [3:0] mode_q;
    logic [1:0] mask_q;
    logic       run_q;
    logic [9:0] duty_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // shadow copies of the fields the assertions lean on
    always @(posedge mclk) begin
        if (!reset_n) begin
            mode_q <= 4'h0;
            mask_q <= 2'h0;
            run_q  <= 1'b0;
            duty_q <= 10'h000;
        end else if (wr_stb) begin
            if (addr == 4'h5) mode_q <= wdata[3:0];
            if (addr == 4'h7) mask_q <= wdata[1:0];
            if (addr == 4'h2) run_q <= wdata[2];
            if (addr == 4'h3) duty_q[9:2] <= wdata;
            if (addr == 4'h5) duty_q[1:0] <= wdata[5:4];
        end
    end
    rdata_idle_a: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_stb && addr[3] |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_clear_a: assert property (wr_stb && addr == 4'h5 && wdata == 8'h00 |=> ##1 !unit2_output_pin)
        else $error("pin not forced low");
    mode_off_a: assert property ($past(mode_q) != 4'hC |-> !unit2_output_pin)
        else $error("pin high outside pwm mode");
    run_rise_a: assert property ($rose(unit2_output_pin) |-> $past(run_q) || $past(run_q, 2) || $past(run_q, 3))
        else $error("pin rose with time base stopped");
    zero_duty_a: assert property ($rose(unit2_output_pin) |->
        ($past(duty_q) | $past(duty_q, 2) | $past(duty_q, 3)) != 10'h000)
        else $error("pin rose with zero duty");
    irq_mask_a: assert property (irq |-> $past(mask_q) != 2'h0)
        else $error("interrupt while masked");
    mask_off_a: assert property (wr_stb && addr == 4'h7 && wdata[1:0] == 2'h0 |=> ##1 !irq)
        else $error("interrupt stayed after mask cleared");
endmodule // pwm_period_duty_generator_chk
bind pwm_period_duty_generator pwm_period_duty_generator_chk chk_u (.mclk(mclk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .unit2_output_pin(unit2_output_pin), .irq(irq));
`default_nettype wire

// ===== sim/pwm_period_duty_generator_test.sv
// testbench for the pwm generator: register access and pin timing
`timescale 1ns/1ns
`default_nettype none
module pwm_period_duty_generator_test;
    logic        mclk, reset_n, wr_stb, rd_stb;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    wire  [7:0]  rdata;
    wire         pin, irq;
    wire  [15:0] high, period, rises;
    logic [15:0] r0;
    int          bad_count = 0, samples_checked = 0, cyc = 0;
    pwm_period_duty_generator dut_u (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .unit2_output_pin(pin), .irq(irq));
    pwm_load_model load_u (.mclk(mclk), .unit2_output_pin(pin), .last_high(high),
        .last_period(period), .rises(rises));
    // 250 MHz clock
    always #2 mclk = ~mclk;
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test;
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        chk("rdata", {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // main sequence
    initial begin
        mclk = 0; reset_n = 0; addr = 4'h0; wdata = 8'h00; wr_stb = 0; rd_stb = 0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        rd(4'h1, 8'hFF); rd(4'h3, 8'h00); rd(4'h8, 8'h00);
        wr(4'h1, 8'h01); wr(4'h3, 8'h01); wr(4'h2, 8'h7C); wr(4'h7, 8'h01); wr(4'h5, 8'h0C);
        w(40); chk("high", 16'h0004, high);
        chk("period", 16'h0008, period);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(4'h4, 8'hAA); rd(4'h4, 8'h01);
        wr(4'h3, 8'h00); wr(4'h5, 8'h3C); w(40); chk("high", 16'h0003, high);
        wr(4'h3, 8'h05); w(40); chk("pin", 16'h0001, {15'h0, pin});
        wr(4'h3, 8'h00); wr(4'h5, 8'h0C); w(24); r0 = rises;
        w(40); chk("rises", r0, rises);
        wr(4'h3, 8'h01); wr(4'h2, 8'h05); w(120); chk("high", 16'h0010, high);
        chk("period", 16'h0020, period);
        wr(4'h5, 8'h00); w(3); chk("pin", 16'h0000, {15'h0, pin});
        wr(4'h5, 8'h0C); wr(4'h2, 8'h00); wr(4'h6, 8'h03); w(3); chk("irq", 16'h0000, {15'h0, irq});
        r0 = rises; w(100); chk("rises", r0, rises);
        wr(4'h7, 8'h00); w(3);
        end_of_test;
    end
endmodule // pwm_period_duty_generator_test
`default_nettype wire
